// [shared/owl_pkg.sv]
// Constants and carrier types for the single-wire host link, device end
package owl_pkg;

	// ----------------------------------------------------------------
	// Clock
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 20;

	// ----------------------------------------------------------------
	// Times in microseconds
	// ----------------------------------------------------------------
	localparam int BREAK_LOW_TIME_US = 190;
	localparam int BREAK_RECOVERY_TIME_US = 40;
	localparam int HOST_ONE_PULSE_MAX_US = 50;
	localparam int HOST_ZERO_PULSE_MIN_US = 86;
	localparam int HOST_ZERO_PULSE_MAX_US = 145;
	localparam int HOST_BIT_PERIOD_US = 190;
	localparam int DEVICE_BIT_PERIOD_MIN_US = 190;
	localparam int DEVICE_BIT_PERIOD_US = 205;
	localparam int DEVICE_BIT_PERIOD_MAX_US = 250;
	localparam int DEVICE_ONE_PULSE_MIN_US = 32;
	localparam int DEVICE_ONE_PULSE_MAX_US = 50;
	localparam int DEVICE_ZERO_PULSE_MIN_US = 80;
	localparam int DEVICE_ZERO_PULSE_MAX_US = 145;
	localparam int RESPONSE_DELAY_US = 190;
	localparam int HOST_TURNAROUND_DELAY_US = 210;
	localparam int BUS_RESET_MIN_US = 1900000;
	localparam int BUS_RESET_MAX_US = 2100000;

	// ----------------------------------------------------------------
	// Cycle counts
	// ----------------------------------------------------------------
	localparam int DEC_THRESH_US = (HOST_ONE_PULSE_MAX_US + HOST_ZERO_PULSE_MIN_US) / 2;
	localparam int DEV_ONE_US = (DEVICE_ONE_PULSE_MIN_US + DEVICE_ONE_PULSE_MAX_US) / 2;
	localparam int DEV_ZERO_US = (DEVICE_ZERO_PULSE_MIN_US + DEVICE_ZERO_PULSE_MAX_US) / 2;
	localparam int CNT_W = 26;
	localparam int TMR_W = 13;
	localparam logic [CNT_W-1:0] DEC_THRESH_CYC = CNT_W'(DEC_THRESH_US * CLK_MHZ);
	localparam logic [CNT_W-1:0] BREAK_CYC = CNT_W'(BREAK_LOW_TIME_US * CLK_MHZ);
	localparam logic [TMR_W-1:0] DEV_ONE_CYC = TMR_W'(DEV_ONE_US * CLK_MHZ);
	localparam logic [TMR_W-1:0] DEV_ZERO_CYC = TMR_W'(DEV_ZERO_US * CLK_MHZ);
	localparam logic [TMR_W-1:0] RESP_CYC = TMR_W'(RESPONSE_DELAY_US * CLK_MHZ);
	localparam int BIT_PERIOD_CYC = DEVICE_BIT_PERIOD_US * CLK_MHZ;
	localparam int BUS_RESET_CYC = BUS_RESET_MIN_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OWL_IDLE = 2'b00,
		OWL_TX_LOW = 2'b01,
		OWL_TX_HIGH = 2'b10
	} owl_state_e;

	typedef struct packed {
		logic bit_valid;
		logic bit_value;
		logic brk;
		logic bus_reset;
	} owl_rx_s;

endpackage

// [src/owl_link.sv]
// Device end of the single-wire pulse-coded host link
`timescale 1ns/10ps
`default_nettype none
module owl_link
	import owl_pkg::*;
#(
	parameter int BIT_PERIOD = BIT_PERIOD_CYC,
	parameter int BUS_RESET = BUS_RESET_CYC
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Shared line, open drain
	input wire logic line_in,
	output logic line_out,
	output logic line_oe_out,
	// Received host bits and events
	output owl_rx_s rx_out,
	// Response bits to the host
	input wire logic tx_valid_in,
	input wire logic tx_bit_in,
	input wire logic tx_last_in,
	output logic tx_ready_out,
	output logic tx_busy_out
);

	// ----------------------------------------------------------------
	// Line synchroniser
	// ----------------------------------------------------------------
	logic line_meta_reg;
	logic line_sync_reg;
	logic line_prev_reg;
	logic line_meta_next, line_sync_next, line_prev_next;

	// Two flops before any logic reads the pin; the third only feeds the edge detector
	always_comb begin
		line_meta_next = line_in;
		line_sync_next = line_meta_reg;
		line_prev_next = line_sync_reg;
	end

	// Reset to the idle level so no false edge follows reset
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			line_meta_reg <= 1'b1;
			line_sync_reg <= 1'b1;
			line_prev_reg <= 1'b1;
		end else begin
			line_meta_reg <= line_meta_next;
			line_sync_reg <= line_sync_next;
			line_prev_reg <= line_prev_next;
		end
	end

	// ----------------------------------------------------------------
	// Receive: time low pulses and high gaps
	// ----------------------------------------------------------------
	// A low of at least the break time ends as a break, shorter ones as data bits.
	// Pulses seen while the device is answering are its own and are not decoded.
	// The rising edge that ends a link-reset low carries no bit.
	// Link-reset length in cycles, shortened for simulation through the parameter
	localparam logic [CNT_W-1:0] RST_LIM = CNT_W'(BUS_RESET);
	logic [CNT_W-1:0] low_cnt_reg, low_cnt_next;
	logic [TMR_W-1:0] high_cnt_reg, high_cnt_next;
	logic rst_seen_reg, rst_seen_next;
	owl_rx_s rx_reg, rx_next;
	logic rise;
	logic link_reset;
	owl_state_e state_reg, state_next;

	assign rise = line_sync_reg & ~line_prev_reg;
	assign link_reset = ~line_sync_reg & (low_cnt_reg == RST_LIM) & ~rst_seen_reg;

	// Low count saturates at the link-reset length so a stuck-low line fires once
	// High count saturates at the response delay and measures the quiet time before an answer
	always_comb begin
		low_cnt_next = low_cnt_reg;
		high_cnt_next = high_cnt_reg;
		rst_seen_next = rst_seen_reg;
		rx_next = '0;
		if (!line_sync_reg) begin
			high_cnt_next = '0;
			if (low_cnt_reg != RST_LIM)
				low_cnt_next = low_cnt_reg + 1'b1;
			if (link_reset) begin
				rx_next.bus_reset = 1'b1;
				rst_seen_next = 1'b1;
			end
		end else begin
			low_cnt_next = '0;
			if (high_cnt_reg != RESP_CYC)
				high_cnt_next = high_cnt_reg + 1'b1;
			if (rise && !rst_seen_reg && state_reg == OWL_IDLE) begin
				if (low_cnt_reg >= BREAK_CYC) begin
					rx_next.brk = 1'b1;
				end else begin
					rx_next.bit_valid = 1'b1;
					rx_next.bit_value = (low_cnt_reg < DEC_THRESH_CYC);
				end
			end
			rst_seen_next = 1'b0;
		end
	end

	// Registers only; decisions are made in the block above
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			low_cnt_reg <= '0;
			high_cnt_reg <= '0;
			rst_seen_reg <= 1'b0;
			rx_reg <= '0;
		end else begin
			low_cnt_reg <= low_cnt_next;
			high_cnt_reg <= high_cnt_next;
			rst_seen_reg <= rst_seen_next;
			rx_reg <= rx_next;
		end
	end

	assign rx_out = rx_reg;

	// ----------------------------------------------------------------
	// Transmit: pulse-coded response bits
	// ----------------------------------------------------------------
	// The line is only ever pulled low; the pull-up returns a released line high.
	// The period timer saturates at the bit period, so a late tx_valid_in stretches the period;
	// the user must keep the next bit ready to stay inside the longest period.
	// Both pulse lengths stay below the bit period, which must fit the timer width.
	localparam logic [TMR_W-1:0] PERIOD_LIM = TMR_W'(BIT_PERIOD);
	logic [TMR_W-1:0] tmr_reg, tmr_next;
	logic [TMR_W-1:0] pulse_reg, pulse_next;
	logic last_reg, last_next;
	logic drive_reg, drive_next;
	logic take;

	// A bit is taken at a period boundary, or from idle once the line has been quiet long enough
	always_comb begin
		take = 1'b0;
		case (state_reg)
			// First bit only after the line has been quiet for the response delay
			OWL_IDLE: take = tx_valid_in && line_sync_reg && high_cnt_reg == RESP_CYC;
			// Later bits at the end of the current period, unless that bit was the last
			OWL_TX_HIGH: take = tx_valid_in && !last_reg && tmr_reg >= PERIOD_LIM;
			default: take = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Transmit state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		tmr_next = tmr_reg;
		pulse_next = pulse_reg;
		last_next = last_reg;
		drive_next = 1'b0;
		if (take) begin
			state_next = OWL_TX_LOW;
			tmr_next = TMR_W'(1);
			pulse_next = tx_bit_in ? DEV_ONE_CYC : DEV_ZERO_CYC;
			last_next = tx_last_in;
			drive_next = 1'b1;
		end else begin
			case (state_reg)
				OWL_IDLE: begin
					tmr_next = '0;
				end
				// Pull low for the pulse length counted from the take edge
				OWL_TX_LOW: begin
					tmr_next = tmr_reg + 1'b1;
					drive_next = tmr_reg < pulse_reg;
					if (tmr_reg >= pulse_reg)
						state_next = OWL_TX_HIGH;
				end
				// Hold the rest of the period, then go idle after the last bit
				OWL_TX_HIGH: begin
					if (tmr_reg < PERIOD_LIM)
						tmr_next = tmr_reg + 1'b1;
					else if (last_reg)
						state_next = OWL_IDLE;
				end
				default: state_next = OWL_IDLE;
			endcase
		end
		// A link reset abandons any response and lets go of the line at once
		if (link_reset) begin
			state_next = OWL_IDLE;
			drive_next = 1'b0;
		end
	end

	// Registers only; decisions are made in the block above
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= OWL_IDLE;
			tmr_reg <= '0;
			pulse_reg <= '0;
			last_reg <= 1'b0;
			drive_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			pulse_reg <= pulse_next;
			last_reg <= last_next;
			drive_reg <= drive_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Handshake outputs are combinational; the line enable comes straight from a flop
	assign tx_ready_out = take;
	assign tx_busy_out = state_reg != OWL_IDLE;
	assign line_out = 1'b0;
	assign line_oe_out = drive_reg;

endmodule // owl_link
`default_nettype wire

// [bench/owl_link_chk.sv]
// Checker on the ports of the link device end
`timescale 1ns/10ps
`default_nettype none
module owl_link_chk
	import owl_pkg::*;
#(
	parameter int BIT_PERIOD = BIT_PERIOD_CYC,
	parameter int BUS_RESET = BUS_RESET_CYC
) (
	// Watched ports
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic line_in,
	input wire logic line_out,
	input wire logic line_oe_out,
	input wire owl_rx_s rx_out,
	input wire logic tx_ready_out,
	input wire logic tx_busy_out
);
	// ----
	// Line timers
	// ----
	int lo_c, lo_len, hi_c, oe_c, per_c;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lo_c <= 0;
			lo_len <= 0;
			hi_c <= 0;
			oe_c <= 0;
			per_c <= 0;
		end else begin
			lo_c <= line_in ? 0 : lo_c + 1;
			hi_c <= line_in ? hi_c + 1 : 0;
			oe_c <= line_oe_out ? oe_c + 1 : 0;
			per_c <= $rose(line_oe_out) ? 1 : per_c + 1;
			if (line_in && lo_c != 0)
				lo_len <= lo_c;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence tx_take;
		tx_ready_out;
	endsequence
	sequence first_rise;
		$rose(line_oe_out) && !$past(tx_busy_out);
	endsequence
	line_low_a: assert property (line_out == 1'b0) else $error("line driven high");
	drive_busy_a: assert property (line_oe_out |-> tx_busy_out) else $error("pull outside response");
	tx_start_a: assert property (tx_take |=> line_oe_out) else $error("taken bit not started");
	resp_gap_a: assert property (first_rise |-> hi_c >= 3800) else $error("response too early");
	bit_space_a: assert property ($rose(line_oe_out) && $past(tx_busy_out) |-> per_c inside {[3800:5000]})
		else $error("bit period out of range");
	pulse_len_a: assert property ($fell(line_oe_out) |-> oe_c inside {[640:1000], [1600:2900]})
		else $error("pulse width out of range");
	rx_time_a: assert property (rx_out.bit_valid || rx_out.brk |-> $past(line_in, 3) && !$past(line_in, 4))
		else $error("receive event mistimed");
	rx_value_a: assert property (rx_out.bit_valid |-> rx_out.bit_value == (lo_len < int'(DEC_THRESH_CYC)))
		else $error("bit decoded wrongly");
	brk_len_a: assert property (rx_out.brk |-> lo_len >= int'(BREAK_CYC)) else $error("short break");
	bus_rst_a: assert property (rx_out.bus_reset |-> lo_c >= BUS_RESET && lo_c <= BUS_RESET + 6)
		else $error("bus reset mistimed");
endmodule // owl_link_chk
`default_nettype wire

// [bench/owl_host_model.sv]
// Host end model pulling the shared line low
`timescale 1ns/10ps
`default_nettype none
module owl_host_model (
	// Clock and line pull
	input wire logic clk_in,
	output logic low_out
);
	initial low_out = 1'b0;
	task automatic pulse(input int low);
		@(negedge clk_in);
		low_out = 1'b1;
		repeat (low) @(negedge clk_in);
		low_out = 1'b0;
	endtask
endmodule // owl_host_model
`default_nettype wire

// [bench/owl_link_tb.sv]
// Testbench for the link device end
`timescale 1ns/10ps
`default_nettype none
module owl_link_tb;
	import owl_pkg::*;
	localparam int RST_CYC = 5000;
	typedef struct {int low; owl_rx_s exp;} owl_row_s;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic tx_valid_in = 1'b0;
	logic tx_bit_in = 1'b0;
	logic tx_last_in = 1'b0;
	logic host_low, line_oe_out, line_out, tx_ready_out, tx_busy_out;
	wire logic line_in;
	owl_rx_s rx_out;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	owl_row_s rows[6] = '{'{3900, 4'h2}, '{10, 4'hc}, '{1000, 4'hc}, '{1300, 4'hc}, '{1720, 4'h8}, '{2900, 4'h8}};
	assign line_in = !(host_low || line_oe_out);
	always #25 clk_in = !clk_in;
	owl_host_model owl_host_model_i (.clk_in(clk_in), .low_out(host_low));
	owl_link #(.BUS_RESET(RST_CYC)) owl_link_i (.clk_in(clk_in), .rst_in(rst_in), .line_in(line_in),
		.line_out(line_out), .line_oe_out(line_oe_out), .rx_out(rx_out), .tx_valid_in(tx_valid_in),
		.tx_bit_in(tx_bit_in), .tx_last_in(tx_last_in), .tx_ready_out(tx_ready_out), .tx_busy_out(tx_busy_out));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic host_bit(input int low, input owl_rx_s exp);
		owl_rx_s got = '0;
		fork
			owl_host_model_i.pulse(low);
			repeat (low + 10) begin
				@(negedge clk_in);
				got = got | rx_out;
			end
		join
		chk(16'(got), 16'(exp));
		repeat (3800) @(negedge clk_in);
	endtask
	task automatic tx_bit(input logic b, input logic last, input logic [15:0] exp);
		int n = 0;
		tx_valid_in = 1'b1;
		tx_bit_in = b;
		tx_last_in = last;
		#1;
		while (tx_ready_out !== 1'b1 && n < 6000) begin
			n++;
			@(negedge clk_in);
			#1;
		end
		chk(16'(tx_ready_out), 16'h1);
		n = 0;
		@(negedge clk_in);
		tx_valid_in = 1'b0;
		while (line_oe_out === 1'b1 && n < 4000) begin
			n++;
			@(negedge clk_in);
		end
		chk(16'(n), exp);
	endtask
	initial begin
		repeat (4) @(negedge clk_in);
		rst_in = 1'b0;
		chk(16'({rx_out, line_oe_out, tx_busy_out, tx_ready_out}), 16'h0);
		foreach (rows[i]) host_bit(rows[i].low, rows[i].exp);
		host_bit(RST_CYC + 400, 4'h1);
		tx_bit(1'b1, 1'b0, 16'(DEV_ONE_CYC));
		tx_bit(1'b0, 1'b1, 16'(DEV_ZERO_CYC));
		repeat (2000) @(negedge clk_in);
		chk(16'(tx_busy_out), 16'h0);
		final_report();
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 90000) begin
			bad_count++;
			final_report();
		end
	end
endmodule // owl_link_tb
bind owl_link owl_link_chk #(.BIT_PERIOD(BIT_PERIOD), .BUS_RESET(BUS_RESET)) owl_link_chk_i (.clk_in(clk_in),
	.rst_in(rst_in), .line_in(line_in), .line_out(line_out), .line_oe_out(line_oe_out), .rx_out(rx_out),
	.tx_ready_out(tx_ready_out), .tx_busy_out(tx_busy_out));
`default_nettype wire
